//--- dtc_pkg.sv
// Constants and types for the dual time base capture/compare unit
`default_nettype none
package dtc_pkg;
  localparam int NCH   = 16;
  localparam int IRQ_W = 18;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_TCFG0 = 8'h00;
  localparam logic [7:0] OFF_TCFG1 = 8'h04;
  localparam logic [7:0] OFF_TVAL0 = 8'h08;
  localparam logic [7:0] OFF_TVAL1 = 8'h0C;
  localparam logic [7:0] OFF_REL0  = 8'h10;
  localparam logic [7:0] OFF_REL1  = 8'h14;
  localparam logic [7:0] OFF_GCTL  = 8'h18;
  localparam logic [7:0] OFF_ISTAT = 8'h1C;
  localparam logic [7:0] OFF_ICLR  = 8'h20;
  localparam logic [7:0] OFF_IEN   = 8'h24;
  localparam logic [7:0] OFF_CFG   = 8'h40;
  localparam logic [7:0] OFF_VAL   = 8'h80;
  localparam logic [7:0] OFF_END   = 8'hC0;
  localparam int IRQ_OVF_POS = 16;
  // ----------------------------------------
  // Modes and layouts
  // ----------------------------------------
  typedef enum logic [2:0] {
    DTC_OFF  = 3'b000,
    DTC_CAP  = 3'b001,
    DTC_CMP0 = 3'b010,
    DTC_CMP1 = 3'b011,
    DTC_CMP2 = 3'b100,
    DTC_CMP3 = 3'b101
  } dtc_mode_e;
  typedef enum logic [1:0] {
    DTC_SRC_PSC = 2'b00,
    DTC_SRC_AUX = 2'b01,
    DTC_SRC_EXT = 2'b10
  } dtc_src_e;
  // Bits [7:0]: sev, dbl, edg[1:0], mode[2:0], tsel
  typedef struct packed {
    logic      sev;
    logic      dbl;
    logic [1:0] edg;
    dtc_mode_e mode;
    logic      tsel;
  } dtc_chcfg_s;
  // Bits [6:0]: psc exponent[3:0], src[1:0], run
  typedef struct packed {
    logic [3:0] psc;
    dtc_src_e   src;
    logic       run;
  } dtc_tcfg_s;
  localparam dtc_chcfg_s CHCFG_RST = 8'h00;
  localparam dtc_tcfg_s  TCFG_RST  = 7'h00;
  localparam logic [15:0] TMR_RST  = 16'h0000;
  localparam logic [15:0] TMR_TOP  = 16'hFFFF;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : dtc_pkg
`default_nettype wire

//--- dtc_unit.sv
// Dual time base capture/compare unit with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module dtc_unit (
  input  wire logic        mclk_i,          // System clock
  input  wire logic        rst_i,           // Async reset, high
  input  wire logic [7:0]  s_axi_awaddr_i,  // Write address
  input  wire logic        s_axi_awvalid_i, // Write address valid
  output logic             s_axi_awready_o, // Write address ready
  input  wire logic [31:0] s_axi_wdata_i,   // Write data
  input  wire logic [3:0]  s_axi_wstrb_i,   // Byte enables
  input  wire logic        s_axi_wvalid_i,  // Write data valid
  output logic             s_axi_wready_o,  // Write data ready
  output logic [1:0]       s_axi_bresp_o,   // Write response
  output logic             s_axi_bvalid_o,  // Write response valid
  input  wire logic        s_axi_bready_i,  // Write response ready
  input  wire logic [7:0]  s_axi_araddr_i,  // Read address
  input  wire logic        s_axi_arvalid_i, // Read address valid
  output logic             s_axi_arready_o, // Read address ready
  output logic [31:0]      s_axi_rdata_o,   // Read data
  output logic [1:0]       s_axi_rresp_o,   // Read response
  output logic             s_axi_rvalid_o,  // Read data valid
  input  wire logic        s_axi_rready_i,  // Read data ready
  input  wire logic [15:0] pin_i,           // Channel pins in
  output logic [15:0]      pin_o,           // Channel pins out
  output logic [15:0]      pin_oe_o,        // Channel pin drive
  input  wire logic        auxiliary_timer_overflow_source_i, // Aux timer event
  input  wire logic [1:0]  ext_cnt_i,       // Count pins per timer
  output logic             irq_o            // Interrupt level
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[b*8 +: 8] = n[b*8 +: 8];
    end
    return r;
  endfunction : merge

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= dtc_pkg::OFF_IEN || (a >= dtc_pkg::OFF_CFG && a < dtc_pkg::OFF_END));
  endfunction : mapped

  function automatic logic psc_hit(input logic [10:0] c, input logic [3:0] e);
    logic [10:0] m;
    m = 11'((12'h001 << e) - 12'h001);
    return (c & m) == m;
  endfunction : psc_hit

  // ----------------------------------------
  // State
  // ----------------------------------------
  dtc_pkg::dtc_tcfg_s  tcfg_reg [2];
  dtc_pkg::dtc_chcfg_s cfg_reg  [dtc_pkg::NCH];
  logic [15:0]         tmr_reg  [2];
  logic [15:0]         rel_reg  [2];
  logic [15:0]         val_reg  [dtc_pkg::NCH];
  logic                stag_reg;
  logic [10:0]         psc_reg;
  logic [17:0]         ist_reg, ien_reg;
  logic [15:0]         pin_reg, oe_reg, hit_reg, sevd_reg;
  logic [15:0]         s1_reg, s2_reg, s3_reg;
  logic [1:0]          e1_reg, e2_reg, e3_reg;
  logic [1:0]          tickq_reg, ovfq_reg;
  logic                irq_reg, bvalid_reg, rvalid_reg;
  logic [1:0]          bresp_reg, rresp_reg;
  logic [31:0]         rdata_reg;
  logic [1:0]          tick, ovf, ext_rise, wt;
  logic [15:0]         cap, cmp, tog, set3, clr3, match, wcfg, wval;
  logic                wr_go, rd_go;
  logic [31:0]         rd_data;
  logic [3:0]          wi, ri;

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  // Both write channels taken together; one transfer at a time
  assign wr_go           = s_axi_awvalid_i & s_axi_wvalid_i & ~bvalid_reg;
  assign s_axi_awready_o = wr_go;
  assign s_axi_wready_o  = wr_go;
  assign rd_go           = s_axi_arvalid_i & ~rvalid_reg;
  assign s_axi_arready_o = rd_go;
  assign s_axi_bvalid_o  = bvalid_reg;
  assign s_axi_bresp_o   = bresp_reg;
  assign s_axi_rvalid_o  = rvalid_reg;
  assign s_axi_rresp_o   = rresp_reg;
  assign s_axi_rdata_o   = rdata_reg;
  assign wi              = s_axi_awaddr_i[5:2];
  assign ri              = s_axi_araddr_i[5:2];
  assign wt[0]           = wr_go && s_axi_awaddr_i == dtc_pkg::OFF_TVAL0;
  assign wt[1]           = wr_go && s_axi_awaddr_i == dtc_pkg::OFF_TVAL1;

  always_comb begin
    for (int n = 0; n < dtc_pkg::NCH; n++) begin
      wcfg[n] = wr_go && s_axi_awaddr_i == (dtc_pkg::OFF_CFG + 8'(n * 4));
      wval[n] = wr_go && s_axi_awaddr_i == (dtc_pkg::OFF_VAL + 8'(n * 4));
    end
  end

  // Write response
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= dtc_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= mapped(s_axi_awaddr_i) ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read mux; unmapped reads get an error and return zero except misaligned ones in 0x40-0xBF
  always_comb begin
    rd_data = 32'h0000_0000;
    case (s_axi_araddr_i[7:6])
      2'b01:   rd_data = {24'h000000, cfg_reg[ri]};
      2'b10:   rd_data = {16'h0000, val_reg[ri]};
      2'b00: begin
        case (s_axi_araddr_i)
          dtc_pkg::OFF_TCFG0: rd_data = {25'h0000000, tcfg_reg[0]};
          dtc_pkg::OFF_TCFG1: rd_data = {25'h0000000, tcfg_reg[1]};
          dtc_pkg::OFF_TVAL0: rd_data = {16'h0000, tmr_reg[0]};
          dtc_pkg::OFF_TVAL1: rd_data = {16'h0000, tmr_reg[1]};
          dtc_pkg::OFF_REL0:  rd_data = {16'h0000, rel_reg[0]};
          dtc_pkg::OFF_REL1:  rd_data = {16'h0000, rel_reg[1]};
          dtc_pkg::OFF_GCTL:  rd_data = {31'h00000000, stag_reg};
          dtc_pkg::OFF_ISTAT: rd_data = {14'h0000, ist_reg};
          dtc_pkg::OFF_IEN:   rd_data = {14'h0000, ien_reg};
          default:            rd_data = 32'h0000_0000;
        endcase
      end
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= dtc_pkg::RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
    end else if (rd_go) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= mapped(s_axi_araddr_i) ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
      rdata_reg  <= rd_data;
    end else if (s_axi_rready_i) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Timer setup and global registers
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tcfg_reg[0] <= dtc_pkg::TCFG_RST;
      tcfg_reg[1] <= dtc_pkg::TCFG_RST;
      rel_reg[0]  <= dtc_pkg::TMR_RST;
      rel_reg[1]  <= dtc_pkg::TMR_RST;
      stag_reg    <= 1'b0;
      ien_reg     <= 18'h00000;
    end else if (wr_go) begin
      case (s_axi_awaddr_i)
        dtc_pkg::OFF_TCFG0: tcfg_reg[0] <= 7'(merge(32'(tcfg_reg[0]), s_axi_wdata_i, s_axi_wstrb_i));
        dtc_pkg::OFF_TCFG1: tcfg_reg[1] <= 7'(merge(32'(tcfg_reg[1]), s_axi_wdata_i, s_axi_wstrb_i));
        dtc_pkg::OFF_REL0:  rel_reg[0] <= 16'(merge(32'(rel_reg[0]), s_axi_wdata_i, s_axi_wstrb_i));
        dtc_pkg::OFF_REL1:  rel_reg[1] <= 16'(merge(32'(rel_reg[1]), s_axi_wdata_i, s_axi_wstrb_i));
        dtc_pkg::OFF_GCTL:  stag_reg <= s_axi_wstrb_i[0] ? s_axi_wdata_i[0] : stag_reg;
        dtc_pkg::OFF_IEN:   ien_reg <= 18'(merge(32'(ien_reg), s_axi_wdata_i, s_axi_wstrb_i));
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Edge counts when stage two holds the new level and stage three still the old one
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_reg <= 16'h0000;
      s2_reg <= 16'h0000;
      s3_reg <= 16'h0000;
      e1_reg <= 2'b00;
      e2_reg <= 2'b00;
      e3_reg <= 2'b00;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      e1_reg <= ext_cnt_i;
      e2_reg <= e1_reg;
      e3_reg <= e2_reg;
    end
  end
  assign ext_rise = e2_reg & ~e3_reg;

  // ----------------------------------------
  // Time bases
  // ----------------------------------------
  // Free prescaler; staggered mode adds 3 to the exponent, a divide by eight for exponents 0 to 8
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) psc_reg <= 11'h000;
    else       psc_reg <= psc_reg + 11'h001;
  end

  always_comb begin
    for (int t = 0; t < 2; t++) begin
      case (tcfg_reg[t].src)
        dtc_pkg::DTC_SRC_PSC: tick[t] = psc_hit(psc_reg, tcfg_reg[t].psc + (stag_reg ? 4'h3 : 4'h0));
        dtc_pkg::DTC_SRC_AUX: tick[t] = auxiliary_timer_overflow_source_i;
        dtc_pkg::DTC_SRC_EXT: tick[t] = ext_rise[t];
        default:              tick[t] = 1'b0;
      endcase
      tick[t] = tick[t] & tcfg_reg[t].run;
      ovf[t]  = tick[t] && tmr_reg[t] == dtc_pkg::TMR_TOP;
    end
  end

  // Count up; reload at overflow; software write wins over a tick
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tmr_reg[0] <= dtc_pkg::TMR_RST;
      tmr_reg[1] <= dtc_pkg::TMR_RST;
      tickq_reg  <= 2'b00;
      ovfq_reg   <= 2'b00;
    end else begin
      for (int t = 0; t < 2; t++) begin
        if (wt[t]) tmr_reg[t] <= 16'(merge(32'(tmr_reg[t]), s_axi_wdata_i, s_axi_wstrb_i));
        else if (ovf[t]) tmr_reg[t] <= rel_reg[t];
        else if (tick[t]) tmr_reg[t] <= tmr_reg[t] + 16'h0001;
      end
      tickq_reg <= tick & ~wt;
      ovfq_reg  <= ovf & ~wt;
    end
  end

  // ----------------------------------------
  // Channel events
  // ----------------------------------------
  // Compare runs one cycle after each count, against the new count
  always_comb begin
    for (int n = 0; n < dtc_pkg::NCH; n++) begin
      automatic logic t = cfg_reg[n].tsel;
      automatic dtc_pkg::dtc_mode_e m = cfg_reg[n].mode;
      automatic logic once = (m == dtc_pkg::DTC_CMP2) || (m == dtc_pkg::DTC_CMP3);
      match[n] = tickq_reg[t] && tmr_reg[t] == val_reg[n];
      cmp[n]   = match[n] && m >= dtc_pkg::DTC_CMP0 && m <= dtc_pkg::DTC_CMP3
                 && !(once && hit_reg[n]) && !(cfg_reg[n].sev && sevd_reg[n]);
      cap[n]   = m == dtc_pkg::DTC_CAP && ((cfg_reg[n].edg[0] && s2_reg[n] && !s3_reg[n])
                 || (cfg_reg[n].edg[1] && !s2_reg[n] && s3_reg[n]));
      set3[n]  = cmp[n] && m == dtc_pkg::DTC_CMP3;
      clr3[n]  = ovfq_reg[t] && m == dtc_pkg::DTC_CMP3;
    end
    // Double pair: own matches outside mode 3 and partner matches each toggle the lower pin once
    for (int n = 0; n < dtc_pkg::NCH; n++) begin
      tog[n] = cmp[n] && cfg_reg[n].mode == dtc_pkg::DTC_CMP1;
      if (n < 8 && cfg_reg[n].dbl) tog[n] = (cmp[n] && !set3[n]) ^ cmp[(n + 8) % 16];
    end
  end

  // Channel setup; writing it also rearms a spent single event
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int n = 0; n < dtc_pkg::NCH; n++) cfg_reg[n] <= dtc_pkg::CHCFG_RST;
    end else begin
      for (int n = 0; n < dtc_pkg::NCH; n++) begin
        if (wcfg[n] && s_axi_wstrb_i[0]) cfg_reg[n] <= s_axi_wdata_i[7:0];
      end
    end
  end

  // Capture beats a software write in the same cycle
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int n = 0; n < dtc_pkg::NCH; n++) val_reg[n] <= dtc_pkg::TMR_RST;
    end else begin
      for (int n = 0; n < dtc_pkg::NCH; n++) begin
        if (cap[n]) val_reg[n] <= tmr_reg[cfg_reg[n].tsel];
        else if (wval[n]) val_reg[n] <= 16'(merge(32'(val_reg[n]), s_axi_wdata_i, s_axi_wstrb_i));
      end
    end
  end

  // Period and single event memory; a new event wins over its clear
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      hit_reg  <= 16'h0000;
      sevd_reg <= 16'h0000;
    end else begin
      for (int n = 0; n < dtc_pkg::NCH; n++) begin
        hit_reg[n]  <= cmp[n] | (hit_reg[n] & ~ovfq_reg[cfg_reg[n].tsel]);
        sevd_reg[n] <= (cmp[n] & cfg_reg[n].sev) | (sevd_reg[n] & ~wcfg[n]);
      end
    end
  end

  // Pin drive; only mode 1, mode 3 and lower double channels drive their pins
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_reg <= 16'h0000;
      oe_reg  <= 16'h0000;
    end else begin
      for (int n = 0; n < dtc_pkg::NCH; n++) begin
        if (set3[n]) pin_reg[n] <= 1'b1;
        else if (clr3[n]) pin_reg[n] <= 1'b0;
        else pin_reg[n] <= pin_reg[n] ^ tog[n];
        oe_reg[n] <= cfg_reg[n].mode == dtc_pkg::DTC_CMP1 || cfg_reg[n].mode == dtc_pkg::DTC_CMP3
                     || (n < 8 && cfg_reg[n].dbl);
        // Upper partner of a pair; the modulo keeps the index in range
        if (n >= 8 && cfg_reg[(n + 8) % 16].dbl) oe_reg[n] <= 1'b0;
      end
    end
  end
  assign pin_o    = pin_reg;
  assign pin_oe_o = oe_reg;

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  // Sticky status; a set in the clear cycle is kept
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ist_reg <= 18'h00000;
      irq_reg <= 1'b0;
    end else begin
      ist_reg <= (ist_reg & ~((wr_go && s_axi_awaddr_i == dtc_pkg::OFF_ICLR) ? s_axi_wdata_i[17:0] : 18'h00000))
                 | {ovfq_reg, cap | cmp};
      irq_reg <= |(ist_reg & ien_reg);
    end
  end
  assign irq_o = irq_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_tmr_reload: assert property (@(posedge mclk_i) disable iff (rst_i)
    ovf[0] && !wt[0] |=> tmr_reg[0] == $past(rel_reg[0]) && ovfq_reg[0]) else $error("no reload");
  a_tmr_count: assert property (@(posedge mclk_i) disable iff (rst_i)
    tick[0] && !ovf[0] && !wt[0] |=> tmr_reg[0] == $past(tmr_reg[0]) + 16'h0001) else $error("bad count");
  a_stag_step: assert property (@(posedge mclk_i) disable iff (rst_i)
    stag_reg && tick[0] && tcfg_reg[0].src == dtc_pkg::DTC_SRC_PSC |-> psc_reg[2:0] == 3'h7) else $error("stagger");
  // Channel 2 carries the capture checks and later the mode 2 checks
  a_cap_value: assert property (@(posedge mclk_i) disable iff (rst_i)
    cap[2] |=> val_reg[2] == $past(tmr_reg[cfg_reg[2].tsel])) else $error("capture value");
  a_cap_irq: assert property (@(posedge mclk_i) disable iff (rst_i)
    cap[2] |=> ist_reg[2] ##1 (irq_reg || !ien_reg[2])) else $error("capture irq");
  a_irq_level: assert property (@(posedge mclk_i) disable iff (rst_i)
    ##1 irq_o == |($past(ist_reg) & $past(ien_reg))) else $error("irq level");
  a_cmp0_quiet: assert property (@(posedge mclk_i) disable iff (rst_i)
    cmp[4] && cfg_reg[4].mode == dtc_pkg::DTC_CMP0 && !cfg_reg[4].dbl |=> !pin_oe_o[4] && ist_reg[4])
    else $error("mode 0 pin");
  a_cmp1_toggle: assert property (@(posedge mclk_i) disable iff (rst_i)
    cmp[0] && cfg_reg[0].mode == dtc_pkg::DTC_CMP1 && !cfg_reg[0].dbl |=> pin_o[0] != $past(pin_o[0]))
    else $error("no toggle");
  a_cmp3_pin: assert property (@(posedge mclk_i) disable iff (rst_i)
    set3[1] |=> pin_o[1] ##0 hit_reg[1]) else $error("mode 3 set");
  a_cmp2_once: assert property (@(posedge mclk_i) disable iff (rst_i)
    cmp[2] && cfg_reg[2].mode == dtc_pkg::DTC_CMP2 |=> hit_reg[2] && !cmp[2]) else $error("twice");
  a_sev_once: assert property (@(posedge mclk_i) disable iff (rst_i)
    cmp[3] && cfg_reg[3].sev && !wcfg[3] |=> sevd_reg[3] && !cmp[3]) else $error("single event");
  a_dbl_toggle: assert property (@(posedge mclk_i) disable iff (rst_i)
    cmp[8] && !cmp[0] && cfg_reg[0].dbl && cfg_reg[0].mode != dtc_pkg::DTC_CMP3 |=> pin_o[0] != $past(pin_o[0]))
    else $error("double");
  c_capture: cover property (@(posedge mclk_i) disable iff (rst_i) cap[2]);
  c_mode0:   cover property (@(posedge mclk_i) disable iff (rst_i) cmp[4] && cfg_reg[4].mode == dtc_pkg::DTC_CMP0);
  c_mode3:   cover property (@(posedge mclk_i) disable iff (rst_i) set3[1] ##[1:300] clr3[1]);
  c_double:  cover property (@(posedge mclk_i) disable iff (rst_i) cmp[8] && cfg_reg[0].dbl);
  c_irq:     cover property (@(posedge mclk_i) disable iff (rst_i) irq_o);
endmodule : dtc_unit
`default_nettype wire

//--- dtc_pin_model.sv
// Far-side model of the channel pins and the count sources
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model (
  input  wire logic        mclk_i,   // System clock
  input  wire logic [15:0] pin_o_i,  // Unit pin levels
  input  wire logic [15:0] pin_oe_i, // Unit pin drive
  output logic      [15:0] pin_i_o,  // Resolved pin levels
  output logic             aux_o,    // Auxiliary overflow pulse
  output logic      [1:0]  ext_o     // External count pins
);
  logic [15:0] drv;
  // Wire level: the unit wins where it drives, the outside elsewhere
  assign pin_i_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & drv);
  initial begin
    drv   = 16'h0000;
    aux_o = 1'b0;
    ext_o = 2'b00;
  end
  // Level change on one trigger pin, launched just after an edge
  task automatic set_pin(input int ch, input logic lvl);
    @(posedge mclk_i);
    drv[ch] <= lvl;
  endtask : set_pin
  // One-cycle overflow pulses, spaced so each one counts once
  task automatic pulse_aux(input int n);
    repeat (n) begin
      @(posedge mclk_i);
      aux_o <= 1'b1;
      @(posedge mclk_i);
      aux_o <= 1'b0;
    end
  endtask : pulse_aux
  // Long levels, since the count pins pass a synchroniser first
  task automatic pulse_ext(input int t, input int n);
    repeat (n) begin
      repeat (4) @(posedge mclk_i);
      ext_o[t] <= 1'b1;
      repeat (4) @(posedge mclk_i);
      ext_o[t] <= 1'b0;
    end
  endtask : pulse_ext
endmodule : dtc_pin_model
`default_nettype wire

//--- tb_dual_timebase_capture_compare.sv
// Self-checking bench for the dual time base capture/compare unit
`timescale 1ns/1ps
`default_nettype none
module tb_dual_timebase_capture_compare;
  logic             mclk_i, rst_i, awv, wv, brdy, arv, rrdy;
  logic [7:0]       awa, ara;
  logic [31:0]      wd, d;
  logic [1:0]       r;
  wire logic        awr, wr_rdy, bv, arr, rv, irq, aux;
  wire logic [1:0]  bresp, rresp, ext;
  wire logic [31:0] rdata;
  wire logic [15:0] pin_in, pin_out, pin_oe;
  int               n_fail, total_checks, n, m;
  dtc_unit uut (.mclk_i(mclk_i), .rst_i(rst_i), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wr_rdy), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(brdy),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rrdy), .pin_i(pin_in), .pin_o(pin_out),
    .pin_oe_o(pin_oe), .auxiliary_timer_overflow_source_i(aux), .ext_cnt_i(ext), .irq_o(irq));
  dtc_pin_model pm (.mclk_i(mclk_i), .pin_o_i(pin_out), .pin_oe_i(pin_oe), .pin_i_o(pin_in),
    .aux_o(aux), .ext_o(ext));
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // A bus wait that ran out ends the run as a mismatch
  task automatic stuck(input int k);
    if (k >= 50) begin
      chk("bus handshake", 32'h1, 32'h0);
      complete_run();
    end
  endtask : stuck
  // Address and data offered together, held until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    k = 0;
    do begin @(posedge mclk_i); k++; end while ((awr !== 1'b1 || wr_rdy !== 1'b1) && k < 50);
    stuck(k);
    awv <= 1'b0;
    wv <= 1'b0;
    k = 0;
    do begin @(posedge mclk_i); k++; end while (bv !== 1'b1 && k < 50);
    stuck(k);
    r = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int k;
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    k = 0;
    do begin @(posedge mclk_i); k++; end while (arr !== 1'b1 && k < 50);
    stuck(k);
    arv <= 1'b0;
    k = 0;
    do begin @(posedge mclk_i); k++; end while (rv !== 1'b1 && k < 50);
    stuck(k);
    d = rdata;
    r = rresp;
  endtask : rd
  // Cycles until pin b changes, lim when it never does
  task automatic wchg(input int b, input int lim, output int c);
    logic v;
    v = pin_out[b];
    c = 0;
    while (pin_out[b] === v && c < lim) begin @(posedge mclk_i); c++; end
  endtask : wchg
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_idle();
    chk("pin drive idle", 32'h0, {16'h0000, pin_oe});
    rd(8'hFC);
    chk("unmapped resp", {30'h0, dtc_pkg::RESP_SLVERR}, {30'h0, r});
    wr(8'hF8, 32'h00000000);
    chk("unmapped write resp", {30'h0, dtc_pkg::RESP_SLVERR}, {30'h0, r});
    chk("irq idle", 32'h0, {31'h0, irq});
    $display("test idle done");
  endtask : t_idle
  // Timer 0 reloads FFF0, so a period is 16 ticks
  task automatic t_compare();
    wr(dtc_pkg::OFF_REL0, 32'h0000FFF0);
    wr(dtc_pkg::OFF_TVAL0, 32'h0000FFF0);
    wr(dtc_pkg::OFF_VAL, 32'h0000FFF8);
    wr(dtc_pkg::OFF_VAL + 8'h04, 32'h0000FFF8);
    wr(dtc_pkg::OFF_VAL + 8'h0C, 32'h0000FFF4);
    wr(dtc_pkg::OFF_CFG, 32'h00000006);
    wr(dtc_pkg::OFF_CFG + 8'h04, 32'h0000000A);
    wr(dtc_pkg::OFF_CFG + 8'h0C, 32'h00000086);
    wr(dtc_pkg::OFF_TCFG0, 32'h00000001);
    wchg(0, 400, n);
    wchg(0, 400, n);
    chk("toggle gap", 32'd16, n);
    chk("pin 0 driven", 32'h1, {31'h0, pin_oe[0]});
    wchg(1, 400, n);
    if (pin_out[1] !== 1'b1) wchg(1, 400, n);
    wchg(1, 400, n);
    wchg(1, 400, m);
    chk("set plus clear", 32'd16, n + m);
    chk("set lasts", 32'h1, {31'h0, n < 16});
    wchg(3, 100, n);
    chk("single event", 32'd100, n);
    chk("single edge", 32'h1, {31'h0, pin_out[3]});
    wr(dtc_pkg::OFF_GCTL, 32'h00000001);
    wchg(0, 400, n);
    wchg(0, 400, n);
    chk("staggered gap", 32'd128, n);
    wr(dtc_pkg::OFF_GCTL, 32'h00000000);
    $display("test compare done");
  endtask : t_compare
  task automatic t_capture();
    wr(dtc_pkg::OFF_IEN, 32'h00000004);
    wr(dtc_pkg::OFF_CFG + 8'h08, 32'h00000012);
    pm.set_pin(2, 1'b1);
    repeat (10) @(posedge mclk_i);
    chk("capture irq", 32'h1, {31'h0, irq});
    rd(dtc_pkg::OFF_VAL + 8'h08);
    chk("captured range", 32'h00000FFF, {20'h0, d[15:4]});
    wr(dtc_pkg::OFF_ICLR, 32'h00000004);
    pm.set_pin(2, 1'b0);
    repeat (10) @(posedge mclk_i);
    rd(dtc_pkg::OFF_ISTAT);
    chk("fall ignored", 32'h0, {31'h0, d[2]});
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(dtc_pkg::OFF_CFG + 8'h08, 32'h00000022);
    pm.set_pin(2, 1'b1);
    repeat (10) @(posedge mclk_i);
    rd(dtc_pkg::OFF_ISTAT);
    chk("rise ignored", 32'h0, {31'h0, d[2]});
    pm.set_pin(2, 1'b0);
    repeat (10) @(posedge mclk_i);
    rd(dtc_pkg::OFF_ISTAT);
    chk("fall seen", 32'h1, {31'h0, d[2]});
    $display("test capture done");
  endtask : t_capture
  task automatic t_sources();
    wr(dtc_pkg::OFF_TCFG1, 32'h00000003);
    wr(dtc_pkg::OFF_TVAL1, 32'h00000000);
    pm.pulse_aux(5);
    repeat (4) @(posedge mclk_i);
    rd(dtc_pkg::OFF_TVAL1);
    chk("aux count", 32'd5, d);
    wr(dtc_pkg::OFF_TCFG1, 32'h00000005);
    wr(dtc_pkg::OFF_TVAL1, 32'h00000000);
    pm.pulse_ext(1, 3);
    repeat (8) @(posedge mclk_i);
    rd(dtc_pkg::OFF_TVAL1);
    chk("ext count", 32'd3, d);
    $display("test sources done");
  endtask : t_sources
  // Timer 0 ticks every 16 cycles; rewinding it repeats a match in one period
  task automatic t_modes();
    wr(dtc_pkg::OFF_TCFG0, 32'h00000021);
    chk("write resp", {30'h0, dtc_pkg::RESP_OKAY}, {30'h0, r});
    wr(dtc_pkg::OFF_VAL + 8'h08, 32'h0000FFF8);
    wr(dtc_pkg::OFF_VAL + 8'h10, 32'h0000FFF8);
    wr(dtc_pkg::OFF_CFG + 8'h08, 32'h00000008);
    wr(dtc_pkg::OFF_CFG + 8'h10, 32'h00000004);
    wchg(0, 400, n);
    wr(dtc_pkg::OFF_ICLR, 32'h00000014);
    wr(dtc_pkg::OFF_TVAL0, 32'h0000FFF0);
    repeat (160) @(posedge mclk_i);
    rd(dtc_pkg::OFF_ISTAT);
    chk("read resp", {30'h0, dtc_pkg::RESP_OKAY}, {30'h0, r});
    chk("mode 0 again", 32'h1, {31'h0, d[4]});
    chk("mode 2 once", 32'h0, {31'h0, d[2]});
    chk("mode 0 pin free", 32'h0, {31'h0, pin_oe[4]});
    repeat (256) @(posedge mclk_i);
    rd(dtc_pkg::OFF_ISTAT);
    chk("mode 2 next period", 32'h1, {31'h0, d[2]});
    wr(dtc_pkg::OFF_VAL + 8'h20, 32'h0000FFFC);
    wr(dtc_pkg::OFF_CFG + 8'h20, 32'h00000006);
    wr(dtc_pkg::OFF_CFG, 32'h00000046);
    wchg(0, 400, n);
    wchg(0, 400, n);
    wchg(0, 400, m);
    chk("double period", 32'd256, n + m);
    chk("partner pin free", 32'h0, {31'h0, pin_oe[8]});
    $display("test modes done");
  endtask : t_modes
  // Main sequence after six cycles of reset
  initial begin
    rst_i = 1'b1;
    {awv, wv, brdy, arv, rrdy} = 5'h00;
    {awa, ara, wd, d, r} = '0;
    n_fail = 0;
    total_checks = 0;
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    t_idle();
    t_compare();
    t_capture();
    t_sources();
    t_modes();
    complete_run();
  end
endmodule : tb_dual_timebase_capture_compare
`default_nettype wire
